// ==== design/ppcm_pin_mux.sv ====
// Function select and drive of the three parallel-port control pins.
// Assumes pad cells resolve out/oe pairs; core requests are active high.
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1 - Strap low in reset selects GPIO lines; strap high selects strobes.
// RULE2 - Choice latched at reset release; later strap levels are ignored.
// RULE3 - In GPIO function all three lines are inputs after reset.
// RULE4 - Memory strobes float during reset, then drive high as outputs.
// RULE5 - Pin zero: async read, sync address, column strobe or sync read.
// RULE6 - Pin one: async or sync output enable, or row-address strobe.
// RULE7 - Pin two: async, sync or SDRAM write enable.
// RULE8 - Strobes are active low and sit at one when no access runs.
module ppcm_pin_mux
   import ppcm_pkg::*;
(
   // Clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_b,
   // Strap
   input  wire logic       i_function_strap_pin,
   // Pad side
   input  wire logic       i_ctrl_pin_zero_in,
   input  wire logic       i_ctrl_pin_one_in,
   input  wire logic       i_ctrl_pin_two_in,
   output logic            o_ctrl_pin_zero_out,
   output logic            o_ctrl_pin_zero_oe,
   output logic            o_ctrl_pin_one_out,
   output logic            o_ctrl_pin_one_oe,
   output logic            o_ctrl_pin_two_out,
   output logic            o_ctrl_pin_two_oe,
   // General-purpose side
   input  wire logic [2:0] i_parallel_general_io_out,
   input  wire logic       i_parallel_general_io_dir_we,
   input  wire logic [2:0] i_parallel_general_io_dir,
   output logic [2:0]      o_parallel_general_io_in,
   output logic [2:0]      o_parallel_general_io_dir,
   // Memory interface side
   input  wire logic       i_access_active,
   input  wire ppcm_mem_t  i_mem_type,
   input  wire logic       i_read_enable_select,
   input  wire logic       i_rd_req,
   input  wire logic       i_addr_req,
   input  wire logic       i_oe_req,
   input  wire logic       i_wr_req,
   input  wire logic       i_cas_req,
   input  wire logic       i_ras_req,
   input  wire logic       i_sdwe_req,
   // Status
   output logic            o_emif_mode
);
   // Role request for one pin under the given memory type
   function automatic logic ppcm_role_req(
      input int        pin,
      input ppcm_mem_t mt,
      input logic      rsel,
      input logic      rd,
      input logic      adr,
      input logic      oe,
      input logic      wr,
      input logic      cas,
      input logic      ras,
      input logic      sdwe
   );
      logic r;
      r = 1'b0;
      case (pin)
         PPCM_PIN_ZERO: begin
            case (mt)
               PPCM_MEM_ASYNC: r = rd;
               PPCM_MEM_SYNC:  r = rsel ? rd : adr;
               PPCM_MEM_SDRAM: r = cas;
               default:        r = 1'b0;
            endcase
         end
         PPCM_PIN_ONE: begin
            case (mt)
               PPCM_MEM_ASYNC: r = oe;
               PPCM_MEM_SYNC:  r = oe;
               PPCM_MEM_SDRAM: r = ras;
               default:        r = 1'b0;
            endcase
         end
         PPCM_PIN_TWO: begin
            case (mt)
               PPCM_MEM_ASYNC: r = wr;
               PPCM_MEM_SYNC:  r = wr;
               PPCM_MEM_SDRAM: r = sdwe;
               default:        r = 1'b0;
            endcase
         end
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   ppcm_mode_t mode_w;
   logic       rel_w;
   logic [2:0] oe_q;
   logic [2:0] oe_d;
   logic [2:0] out_q;
   logic [2:0] out_d;
   logic [2:0] dir_q;
   logic [2:0] dir_d;
   logic [2:0] gin_q;
   logic [2:0] pad_in_w;
   logic [2:0] req_w;
   logic       emif_live_w;
   logic       gpio_live_w;
   logic       emif_q;

   ppcm_strap_latch u_strap (
      .i_ref_clk            (i_ref_clk),
      .i_rst_b              (i_rst_b),
      .i_function_strap_pin (i_function_strap_pin),
      .o_mode               (mode_w),
      .o_released           (rel_w)
   );

   assign emif_live_w = (mode_w == PPCM_MODE_EMIF) && rel_w; // RULE1
   assign gpio_live_w = (mode_w == PPCM_MODE_GPIO) && rel_w; // RULE1
   assign pad_in_w    = {i_ctrl_pin_two_in, i_ctrl_pin_one_in,
                         i_ctrl_pin_zero_in};

   // Strobe requests, only while an access is in progress
   assign req_w[PPCM_PIN_ZERO] = i_access_active &&
      ppcm_role_req(PPCM_PIN_ZERO, i_mem_type, i_read_enable_select,
                    i_rd_req, i_addr_req, i_oe_req, i_wr_req,
                    i_cas_req, i_ras_req, i_sdwe_req); // RULE5 RULE8
   assign req_w[PPCM_PIN_ONE] = i_access_active &&
      ppcm_role_req(PPCM_PIN_ONE, i_mem_type, i_read_enable_select,
                    i_rd_req, i_addr_req, i_oe_req, i_wr_req,
                    i_cas_req, i_ras_req, i_sdwe_req); // RULE6 RULE8
   assign req_w[PPCM_PIN_TWO] = i_access_active &&
      ppcm_role_req(PPCM_PIN_TWO, i_mem_type, i_read_enable_select,
                    i_rd_req, i_addr_req, i_oe_req, i_wr_req,
                    i_cas_req, i_ras_req, i_sdwe_req); // RULE7 RULE8

   // Float until released; memory mode always drives, GPIO follows direction
   assign oe_d  = emif_live_w ? PPCM_ALL_DRIVE :
                  gpio_live_w ? dir_q : PPCM_OE_RST; // RULE3 RULE4
   assign out_d = emif_live_w ? ~req_w :
                  gpio_live_w ? i_parallel_general_io_out :
                  PPCM_OUT_RST; // RULE4 RULE8
   assign dir_d = (gpio_live_w && i_parallel_general_io_dir_we) ?
                  i_parallel_general_io_dir : dir_q;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         oe_q   <= PPCM_OE_RST; // RULE4
         out_q  <= PPCM_OUT_RST;
         dir_q  <= PPCM_DIR_RST; // RULE3
         gin_q  <= PPCM_GIN_RST;
         emif_q <= 1'b0;
      end else begin
         oe_q   <= oe_d;
         out_q  <= out_d;
         dir_q  <= dir_d;
         gin_q  <= pad_in_w;
         emif_q <= emif_live_w;
      end
   end

   assign o_ctrl_pin_zero_out       = out_q[PPCM_PIN_ZERO];
   assign o_ctrl_pin_zero_oe        = oe_q[PPCM_PIN_ZERO];
   assign o_ctrl_pin_one_out        = out_q[PPCM_PIN_ONE];
   assign o_ctrl_pin_one_oe         = oe_q[PPCM_PIN_ONE];
   assign o_ctrl_pin_two_out        = out_q[PPCM_PIN_TWO];
   assign o_ctrl_pin_two_oe         = oe_q[PPCM_PIN_TWO];
   assign o_parallel_general_io_in  = gin_q;
   assign o_parallel_general_io_dir = dir_q;
   assign o_emif_mode               = emif_q;

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_b);

   sequence s_emif_live;
      (mode_w == PPCM_MODE_EMIF) && rel_w;
   endsequence

   sequence s_gpio_live;
      (mode_w == PPCM_MODE_GPIO) && rel_w;
   endsequence

   sequence s_release;
      $rose(rel_w);
   endsequence

   a_choice_frozen: assert property ( // RULE2
      rel_w |=> $stable(mode_w))
      else $error("Pin function changed after reset release");

   a_strap_taken: assert property ( // RULE1
      s_release |-> (mode_w == (($past(i_function_strap_pin, 2)) ?
                     PPCM_MODE_EMIF : PPCM_MODE_GPIO)))
      else $error("Pin function differs from strap at release");

   a_gpio_inputs_reset: assert property ( // RULE3
      s_release ##0 s_gpio_live |-> (oe_q == PPCM_OE_RST) ##1
                                    (oe_q == PPCM_OE_RST))
      else $error("GPIO line driven right after reset");

   a_emif_drive_high: assert property ( // RULE4
      s_release ##0 s_emif_live |=> (oe_q == PPCM_ALL_DRIVE) &&
                                    (out_q == ~$past(req_w)))
      else $error("Memory strobe not driven after reset");

   a_pin0_roles: assert property ( // RULE5
      s_emif_live ##0 (i_access_active && i_mem_type == PPCM_MEM_SYNC &&
      (i_read_enable_select ? i_rd_req : i_addr_req))
      |=> !o_ctrl_pin_zero_out && o_ctrl_pin_zero_oe)
      else $error("Pin zero sync role not asserted");

   a_pin0_cas: assert property ( // RULE5
      s_emif_live ##0 (i_access_active && i_mem_type == PPCM_MEM_SDRAM &&
      !i_cas_req) |=> o_ctrl_pin_zero_out)
      else $error("Pin zero low without column strobe");

   a_pin1_roles: assert property ( // RULE6
      s_emif_live ##0 (i_access_active && (i_mem_type == PPCM_MEM_SDRAM ?
      i_ras_req : (i_mem_type != PPCM_MEM_NONE && i_oe_req)))
      |=> !o_ctrl_pin_one_out)
      else $error("Pin one role not asserted");

   a_pin2_roles: assert property ( // RULE7
      s_emif_live ##0 (i_access_active && i_mem_type != PPCM_MEM_NONE &&
      (i_mem_type == PPCM_MEM_SDRAM ? !i_sdwe_req : !i_wr_req))
      |=> o_ctrl_pin_two_out)
      else $error("Pin two low without write role");

   a_idle_high: assert property ( // RULE8
      s_emif_live ##0 !i_access_active [*2] |=>
      (out_q == PPCM_ALL_DRIVE) && (oe_q == PPCM_ALL_DRIVE))
      else $error("Strobe active with no access");

   a_gpio_dir: assert property ( // RULE3
      s_gpio_live ##0 !i_parallel_general_io_dir_we |=>
      $stable(dir_q) ##1 (oe_q == $past(dir_q)))
      else $error("GPIO direction changed without write");
endmodule
`default_nettype wire

// ==== design/ppcm_pkg.sv ====
// Constants and types for the parallel-port control pin mux.
// Assumes one clock domain and a core that supplies strobe requests.
`default_nettype none
package ppcm_pkg;
   localparam int          PPCM_NUM_PINS   = 3;
   localparam int          PPCM_PIN_ZERO   = 0;
   localparam int          PPCM_PIN_ONE    = 1;
   localparam int          PPCM_PIN_TWO    = 2;
   localparam logic [2:0]  PPCM_OE_RST     = 3'h0;
   localparam logic [2:0]  PPCM_OUT_RST    = 3'h0;
   localparam logic [2:0]  PPCM_DIR_RST    = 3'h0;
   localparam logic [2:0]  PPCM_GIN_RST    = 3'h0;
   localparam logic [2:0]  PPCM_ALL_DRIVE  = 3'h7;
   localparam logic        PPCM_STROBE_OFF = 1'h1;
   localparam logic        PPCM_REL_RST    = 1'h0;

   // Pin function chosen by the strap
   typedef enum logic {
      PPCM_MODE_GPIO,
      PPCM_MODE_EMIF
   } ppcm_mode_t;

   // Memory type of the access in progress
   typedef enum logic [1:0] {
      PPCM_MEM_ASYNC,
      PPCM_MEM_SYNC,
      PPCM_MEM_SDRAM,
      PPCM_MEM_NONE
   } ppcm_mem_t;
endpackage
`default_nettype wire

// ==== design/ppcm_strap_latch.sv ====
// Strap capture: follows the strap while reset is low, freezes at release.
// Assumes the clock runs during reset so the strap is sampled.
`timescale 1ns/1ps
`default_nettype none
module ppcm_strap_latch
   import ppcm_pkg::*;
(
   // Clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_b,
   // Strap
   input  wire logic       i_function_strap_pin,
   // Latched choice
   output var  ppcm_mode_t o_mode,
   output logic            o_released
);
   ppcm_mode_t mode_q;
   logic       rel_q;

   assign o_mode     = mode_q;
   assign o_released = rel_q;

   // Sampled only while reset is low, so the last value before release stays
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         mode_q <= i_function_strap_pin ? PPCM_MODE_EMIF :
                                          PPCM_MODE_GPIO; // RULE1 RULE2
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rel_q <= PPCM_REL_RST;
      end else begin
         rel_q <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ==== verification/ppcm_board_model.sv ====
// Board side of the three control pads: memory or GPIO logic.
// Assumes the bench says when the board drives each pad.
`timescale 1ns/1ps
`default_nettype none
module ppcm_board_model (
   // Clock
   input  wire logic       i_ref_clk,
   // Device pad drive
   input  wire logic [2:0] i_dut_out,
   input  wire logic [2:0] i_dut_oe,
   // Board drive
   input  wire logic [2:0] i_ext_en,
   input  wire logic [2:0] i_ext_val,
   // Resolved pads
   output logic [2:0]      o_pad
);
   // Undriven pads have no pull, so they wander every cycle
   logic [2:0] float_q = 3'h5;
   always_ff @(posedge i_ref_clk) begin
      float_q <= ~float_q;
   end
   assign o_pad = (i_dut_oe & i_dut_out) |
                  (~i_dut_oe & i_ext_en & i_ext_val) |
                  (~i_dut_oe & ~i_ext_en & float_q);
endmodule
`default_nettype wire

// ==== verification/parallel_port_control_pin_mux_bench.sv ====
// Bench for the control pin mux: strap, GPIO path and strobe roles.
// Assumes the board model resolves the three pads.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end
module parallel_port_control_pin_mux_bench;
   import ppcm_pkg::*;
   logic       clk = 0, rst_b = 0, strap = 0, dir_we = 0, act = 0, rsel = 0;
   logic [2:0] gout = 0, dir = 0, ext_en = 0, ext_val = 0;
   wire  [2:0] pad, o_out, o_oe, gin, gdir;
   logic [6:0] req = 0;
   wire        emif;
   ppcm_mem_t  mt = PPCM_MEM_NONE;
   int         failures = 0, compares = 0;
   always #5 clk = ~clk;
   ppcm_board_model board (.i_ref_clk(clk), .i_dut_out(o_out),
      .i_dut_oe(o_oe), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(pad));
   ppcm_pin_mux dut (.i_ref_clk(clk), .i_rst_b(rst_b),
      .i_function_strap_pin(strap), .i_ctrl_pin_zero_in(pad[0]),
      .i_ctrl_pin_one_in(pad[1]), .i_ctrl_pin_two_in(pad[2]),
      .o_ctrl_pin_zero_out(o_out[0]), .o_ctrl_pin_zero_oe(o_oe[0]),
      .o_ctrl_pin_one_out(o_out[1]), .o_ctrl_pin_one_oe(o_oe[1]),
      .o_ctrl_pin_two_out(o_out[2]), .o_ctrl_pin_two_oe(o_oe[2]),
      .i_parallel_general_io_out(gout), .i_parallel_general_io_dir_we(dir_we),
      .i_parallel_general_io_dir(dir), .o_parallel_general_io_in(gin),
      .o_parallel_general_io_dir(gdir), .i_access_active(act),
      .i_mem_type(mt), .i_read_enable_select(rsel), .i_rd_req(req[0]),
      .i_addr_req(req[1]), .i_oe_req(req[2]), .i_wr_req(req[3]),
      .i_cas_req(req[4]), .i_ras_req(req[5]), .i_sdwe_req(req[6]),
      .o_emif_mode(emif));

   // Pad levels the strobe roles should give
   function automatic logic [2:0] exp_pins(ppcm_mem_t t, logic a, logic s,
                                           logic [6:0] r);
      logic [2:0] q;
      q = 3'h0;
      if (a && t == PPCM_MEM_ASYNC) q = {r[3], r[2], r[0]};
      else if (a && t == PPCM_MEM_SYNC) q = {r[3], r[2], s ? r[0] : r[1]};
      else if (a && t == PPCM_MEM_SDRAM) q = {r[6], r[5], r[4]};
      return ~q;
   endfunction

   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Reset with a strap level; leaves time just after edge 2 of release
   task automatic do_reset(logic s);
      @(posedge clk);
      rst_b <= 1'h0;
      strap <= s;
      tick(2);
      `CHK("oe_in_reset", 3'h0, o_oe)
      @(posedge clk);
      rst_b <= 1'h1;
      tick(1);
      `CHK("oe_edge1", 3'h0, o_oe)
      tick(1);
   endtask

   task automatic t_gpio;
      do_reset(1'h0);
      `CHK("gpio_mode", 1'h0, emif)
      `CHK("gpio_dir", 3'h0, gdir)
      `CHK("gpio_oe", 3'h0, o_oe)
      @(posedge clk);
      ext_en <= 3'h7;
      ext_val <= 3'h5;
      tick(2);
      `CHK("gpio_in", 3'h5, gin)
      @(posedge clk);
      ext_en <= 3'h4;
      dir_we <= 1'h1;
      dir <= 3'h3;
      gout <= 3'h2;
      strap <= 1'h1;
      @(posedge clk);
      dir_we <= 1'h0;
      #1;
      `CHK("gpio_dir_wr", 3'h3, gdir)
      tick(1);
      `CHK("gpio_oe_wr", 3'h3, o_oe)
      `CHK("gpio_out", 3'h2, o_out)
      tick(2);
      `CHK("gpio_pads", 3'h6, gin)
      `CHK("strap_late", 1'h0, emif)
      $display("test gpio done");
   endtask

   task automatic t_emif;
      do_reset(1'h1);
      `CHK("emif_mode", 1'h1, emif)
      `CHK("emif_oe", 3'h7, o_oe)
      `CHK("emif_idle", 3'h7, o_out)
      @(posedge clk);
      strap <= 1'h0;
      dir_we <= 1'h1;
      dir <= 3'h5;
      tick(3);
      `CHK("emif_dir_we", 3'h7, o_oe)
      `CHK("emif_dir", 3'h0, gdir)
      `CHK("emif_strap", 1'h1, emif)
      @(posedge clk);
      dir_we <= 1'h0;
      $display("test emif done");
   endtask

   task automatic t_roles;
      logic [2:0] e;
      for (int k = 0; k < 1024; k++) begin
         @(posedge clk);
         mt <= ppcm_mem_t'(k[9:8]);
         rsel <= k[7];
         req <= k[6:0];
         act <= (k % 3 != 0);
         tick(1);
         e = exp_pins(mt, act, rsel, req);
         `CHK("pins", e, o_out)
         `CHK("pins_oe", 3'h7, o_oe)
      end
      $display("test roles done");
   endtask

   task automatic final_report;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      t_gpio();
      t_emif();
      t_roles();
      final_report();
   end
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      final_report();
   end
endmodule
`default_nettype wire
